// ===== include/svd_pkg.sv
// Shared constants and types for the supply voltage detect control block
package svd_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAG = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_MONITOR = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_DIR_BIT = 7;
    localparam int CTL_STABLE_BIT = 5;
    localparam int CTL_EN_BIT = 4;
    localparam int LEVEL_W = 4;
    localparam int DETECT_FLAG_BIT = 2;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int MON_CMP_BIT = 0;
    localparam int MON_ARMED_BIT = 1;
    localparam int MON_WAKE_BIT = 2;
    localparam int NUM_TAPS = 15;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h5;
    localparam logic [LEVEL_W-1:0] LEVEL_EXTERNAL = 4'hF;
    localparam logic [7:0] REG8_RESET = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_TIME_NS = 20000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic direction_select;
        logic reserved;
        logic reference_stable_flag;
        logic detect_power_enable;
        logic [LEVEL_W-1:0] trip_level_select;
    } svd_ctrl_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [DATA_W-1:0] wdata;
    } svd_bus_req_t;

    typedef enum logic [1:0] {
        SVD_OFF,
        SVD_SETTLING,
        SVD_ACTIVE
    } svd_state_t;

endpackage

// ===== design/svd_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module svd_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Only a level seen twice in a row is accepted
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clk_sys_i)
        begin
            if (!rst_b_i)
                sync_o[i] <= 1'b0;
            else if (stage2[i] == stage3[i])
                sync_o[i] <= stage3[i];
        end
    end
endmodule

// ===== design/svd_settle_timer.sv
// Reference settling interval counter
`timescale 1ns/100ps
module svd_settle_timer #(
    parameter int CYCLES = 5000
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    output logic done_o
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] count;

    // Restarts whenever run drops, so every enable waits the full time
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i || !run_i)
        begin
            count <= '0;
            done_o <= 1'b0;
        end
        else if (!done_o)
        begin
            if (count == LAST)
                done_o <= 1'b1;
            count <= count + CNT_W'(1);
        end
    end
endmodule

// ===== design/svd_core.sv
// Supply voltage detect control: registers, settling, crossing detect, interrupt
//
// Behaviour
// RL1 - Writing the enable bit 1 powers the monitor and starts detection, writing 0 turns it off.
// RL2 - After each enable the stable flag reads 0 through settling, then 1 once stable.
// RL3 - No detect flag is set while the stable flag is 0, so early crossings may be missed.
// RL4 - Direction bit 0 reports the supply falling below the trip point, 1 reports a rise.
// RL5 - The 4-bit level field selects a trip point, codes 0 to 14 being internal ascending taps.
// RL6 - Level code 15 takes the comparison from the external trip input instead.
// RL7 - The detect flag sets when the supply reaches the trip point in the chosen direction.
// RL8 - Software disables, sets level, sets direction, enables, then clears a stale flag.
// RL9 - The interrupt reaches the processor only with both detect and global enables set.
// RL10 - The settling interval is a fixed time, scaled into cycles from the clock rate.
// RL11 - While enabled the monitor keeps working in sleep and a crossing wakes the device.
// RL12 - Reset returns the control register to its reset value with the monitor off.
// RL13 - The comparison arrives asynchronously, is synchronised, and flags once per crossing.
`timescale 1ns/100ps
module svd_core #(
    parameter int SETTLE_CYCLES = svd_pkg::SETTLE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Avalon-MM slave
    input wire logic [svd_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [svd_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [svd_pkg::DATA_W-1:0] avs_readdata_o,
    output logic [1:0] avs_response_o,
    output logic avs_waitrequest_o,
    // Analog side
    input wire logic [svd_pkg::NUM_TAPS-1:0] tap_above_i,
    input wire logic external_trip_input_i,
    input wire logic sleep_i,
    output logic monitor_power_o,
    output logic [svd_pkg::LEVEL_W-1:0] trip_level_o,
    output logic external_select_o,
    // System
    output logic irq_o,
    output logic wake_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    svd_pkg::svd_bus_req_t req;
    svd_pkg::svd_ctrl_t ctrl;
    logic ctl_dir;
    logic ctl_en;
    logic [svd_pkg::LEVEL_W-1:0] ctl_level;
    svd_pkg::svd_state_t state;
    svd_pkg::svd_state_t next_state;
    logic ack;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic lane0;
    logic hit_control;
    logic hit_flag;
    logic hit_enable;
    logic hit_irqctl;
    logic hit_monitor;
    logic mapped;
    logic detect_irq_flag;
    logic detect_irq_enable;
    logic global_irq_enable;
    logic [svd_pkg::NUM_TAPS:0] cmp_async;
    logic [svd_pkg::NUM_TAPS:0] cmp_sync;
    logic supply_above;
    logic condition;
    logic tripped;
    logic detect_event;
    logic settle_done;
    logic wake;
    logic [7:0] read_byte;

    assign req = '{rd: avs_read_i, wr: avs_write_i, addr: avs_address_i,
                   be: avs_byteenable_i, wdata: avs_writedata_i};

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // One wait cycle per access lets read data come from a flop
    assign bus_req = req.rd | req.wr;
    assign avs_waitrequest_o = bus_req & ~ack;
    assign wr_take = req.wr & ack;
    assign rd_take = req.rd & ~ack;
    assign lane0 = req.be[0];

    assign hit_control = req.addr == svd_pkg::OFS_CONTROL;
    assign hit_flag = req.addr == svd_pkg::OFS_FLAG;
    assign hit_enable = req.addr == svd_pkg::OFS_IRQ_ENABLE;
    assign hit_irqctl = req.addr == svd_pkg::OFS_IRQ_CONTROL;
    assign hit_monitor = req.addr == svd_pkg::OFS_MONITOR;
    assign mapped = hit_control | hit_flag | hit_enable | hit_irqctl | hit_monitor;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            ack <= 1'b0;
        else
            ack <= bus_req & ~ack;
    end

    always_comb
    begin
        read_byte = svd_pkg::REG8_RESET;
        if (hit_control)
            read_byte = ctrl;
        else if (hit_flag)
            read_byte[svd_pkg::DETECT_FLAG_BIT] = detect_irq_flag;
        else if (hit_enable)
            read_byte[svd_pkg::DETECT_FLAG_BIT] = detect_irq_enable;
        else if (hit_irqctl)
            read_byte[svd_pkg::GLOBAL_EN_BIT] = global_irq_enable;
        else if (hit_monitor)
        begin
            read_byte[svd_pkg::MON_CMP_BIT] = supply_above;
            read_byte[svd_pkg::MON_ARMED_BIT] = tripped;
            read_byte[svd_pkg::MON_WAKE_BIT] = wake;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            avs_readdata_o <= '0;
            avs_response_o <= svd_pkg::RESP_OKAY;
        end
        else if (rd_take || (req.wr && !ack))
        begin
            avs_readdata_o <= {{(svd_pkg::DATA_W-8){1'b0}}, read_byte};
            avs_response_o <= mapped ? svd_pkg::RESP_OKAY : svd_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            ctl_dir <= 1'b0; // RL12
            ctl_en <= 1'b0; // RL12
            ctl_level <= svd_pkg::LEVEL_RESET; // RL12
        end
        else if (wr_take && hit_control && lane0)
        begin
            ctl_dir <= req.wdata[svd_pkg::CTL_DIR_BIT]; // RL4
            ctl_en <= req.wdata[svd_pkg::CTL_EN_BIT]; // RL1
            ctl_level <= req.wdata[svd_pkg::LEVEL_W-1:0]; // RL5
        end
    end

    // Stored fields live in their own flops so the struct has a single driver
    assign ctrl = '{direction_select: ctl_dir,
                    reserved: 1'b0,
                    reference_stable_flag: state == svd_pkg::SVD_ACTIVE, // RL2
                    detect_power_enable: ctl_en,
                    trip_level_select: ctl_level};

    assign monitor_power_o = ctrl.detect_power_enable; // RL1
    assign trip_level_o = ctrl.trip_level_select;
    assign external_select_o = ctrl.trip_level_select == svd_pkg::LEVEL_EXTERNAL; // RL6

    // ------------------------------------------------------------
    // Reference settling
    // ------------------------------------------------------------
    // Cycle count derives from a time, not a clock count
    svd_settle_timer #(
        .CYCLES(SETTLE_CYCLES)
    ) u_settle (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .run_i(ctrl.detect_power_enable),
        .done_o(settle_done)
    ); // RL10

    always_comb
    begin
        next_state = state;
        unique case (state)
            svd_pkg::SVD_OFF:
                if (ctrl.detect_power_enable)
                    next_state = svd_pkg::SVD_SETTLING; // RL1
            svd_pkg::SVD_SETTLING:
                if (!ctrl.detect_power_enable)
                    next_state = svd_pkg::SVD_OFF;
                else if (settle_done)
                    next_state = svd_pkg::SVD_ACTIVE; // RL2
            svd_pkg::SVD_ACTIVE:
                if (!ctrl.detect_power_enable)
                    next_state = svd_pkg::SVD_OFF; // RL1
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            state <= svd_pkg::SVD_OFF;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Comparison path
    // ------------------------------------------------------------
    // Every tap is synchronised so a level change never glitches the mux
    assign cmp_async = {external_trip_input_i, tap_above_i};

    svd_sync #(
        .WIDTH(svd_pkg::NUM_TAPS + 1)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .async_i(cmp_async),
        .sync_o(cmp_sync)
    ); // RL13

    assign supply_above = cmp_sync[ctrl.trip_level_select]; // RL5 RL6

    // Fall watch trips below the point, rise watch above it
    assign condition = ctrl.direction_select ? supply_above : ~supply_above; // RL4

    // One event per entry into the condition, no re-trigger while it holds
    assign detect_event = condition & ~tripped & ctrl.reference_stable_flag; // RL3 RL13

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            tripped <= 1'b0;
        else
            tripped <= condition & ctrl.reference_stable_flag; // RL13
    end

    // ------------------------------------------------------------
    // Interrupt registers
    // ------------------------------------------------------------
    // Hardware set beats a same-cycle software clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            detect_irq_flag <= 1'b0;
        else if (detect_event)
            detect_irq_flag <= 1'b1; // RL7
        else if (wr_take && hit_flag && lane0 && req.wdata[svd_pkg::DETECT_FLAG_BIT])
            detect_irq_flag <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            detect_irq_enable <= 1'b0;
        else if (wr_take && hit_enable && lane0)
            detect_irq_enable <= req.wdata[svd_pkg::DETECT_FLAG_BIT];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
            global_irq_enable <= 1'b0;
        else if (wr_take && hit_irqctl && lane0)
            global_irq_enable <= req.wdata[svd_pkg::GLOBAL_EN_BIT];
    end

    assign irq_o = detect_irq_flag & detect_irq_enable & global_irq_enable; // RL9

    // ------------------------------------------------------------
    // Sleep wake
    // ------------------------------------------------------------
    // Wake needs no interrupt enable, only the flag during sleep with the monitor enabled
    assign wake = sleep_i & detect_irq_flag & ctrl.detect_power_enable; // RL11
    assign wake_o = wake;
endmodule

// ===== dv/svd_core_checker.sv
// Concurrent checks on the voltage detect control ports
`timescale 1ns/100ps
module svd_core_checker #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [svd_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [svd_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [svd_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic sleep_i,
    input wire logic monitor_power_o,
    input wire logic [svd_pkg::LEVEL_W-1:0] trip_level_o,
    input wire logic external_select_o,
    input wire logic irq_o,
    input wire logic wake_o
);
    logic wr_done, rd_ctl;
    logic [15:0] on_cnt;
    assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign rd_ctl = avs_read_i && !avs_waitrequest_o && avs_address_i == svd_pkg::OFS_CONTROL;

    // Age of the power-up; saturates so a long enable never wraps back into the window
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i || !monitor_power_o)
        begin
            on_cnt <= 16'h0000;
        end
        else if (on_cnt != 16'hFFFF)
        begin
            on_cnt <= on_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    enable_write_a:
        assert property (wr_done && avs_address_i == svd_pkg::OFS_CONTROL
            |=> monitor_power_o == $past(avs_writedata_i[4])) else $error("enable not applied");
    level_write_a:
        assert property (wr_done && avs_address_i == svd_pkg::OFS_CONTROL
            |=> trip_level_o == $past(avs_writedata_i[3:0])) else $error("level not applied");
    external_sel_a:
        assert property (external_select_o == (trip_level_o == svd_pkg::LEVEL_EXTERNAL))
        else $error("external select wrong");
    reset_state_a:
        assert property (disable iff (1'b0) !rst_b_i |=> !monitor_power_o && !irq_o && !wake_o
            && trip_level_o == svd_pkg::LEVEL_RESET) else $error("reset state wrong");
    settle_low_a:
        assert property (rd_ctl && monitor_power_o && on_cnt >= 2 && on_cnt < SETTLE_CYCLES - 2
            |-> !avs_readdata_o[5]) else $error("stable too early");
    settle_high_a:
        assert property (rd_ctl && on_cnt >= SETTLE_CYCLES + 4 |-> avs_readdata_o[5])
        else $error("stable too late");
    wake_gate_a:
        assert property (wake_o |-> sleep_i && monitor_power_o) else $error("wake without cause");
    irq_gate_a:
        assert property (wr_done && (avs_address_i == svd_pkg::OFS_IRQ_ENABLE
            && !avs_writedata_i[2] || avs_address_i == svd_pkg::OFS_IRQ_CONTROL
            && !avs_writedata_i[7]) |=> !irq_o [*2]) else $error("irq not gated");
endmodule

bind svd_core svd_core_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sleep_i(sleep_i),
    .monitor_power_o(monitor_power_o), .trip_level_o(trip_level_o),
    .external_select_o(external_select_o), .irq_o(irq_o), .wake_o(wake_o)
);

// ===== dv/svd_core_bench.sv
// Self-checking bench for the voltage detect control block
`timescale 1ns/100ps
module svd_core_bench;
    localparam int SETTLE = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic sleep = 1'b0;
    logic [3:0] be = 4'h1;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, got, rdata;
    logic [15:0] sup = 16'hFFFF, msk;
    logic [1:0] resp, got_resp;
    logic [3:0] level;
    logic waitreq, power, ext_sel, irq, wake;
    int miscompares = 0, n_compared = 0, seed = 84869;
    int m_dir = 0, m_en = 0, m_lvl = 5, m_flag = 0, m_ie = 0, m_gie = 0;

    always #2 clk = ~clk;

    svd_core #(.SETTLE_CYCLES(SETTLE)) u_svd_core (
        .clk_sys_i(clk), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_response_o(resp), .avs_waitrequest_o(waitreq),
        .tap_above_i(sup[14:0]), .external_trip_input_i(sup[15]), .sleep_i(sleep),
        .monitor_power_o(power), .trip_level_o(level), .external_select_o(ext_sel),
        .irq_o(irq), .wake_o(wake)
    );

    function automatic logic [31:0] ctl(input int st);
        return (m_dir << 7) | (st << 5) | (m_en << 4) | m_lvl;
    endfunction

    function automatic logic [31:0] pexp();
        return {m_en[0], m_lvl[3:0], m_lvl == 15, m_ie[0] & m_gie[0] & m_flag[0],
            sleep & m_flag[0] & m_en[0]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Waitrequest is sampled on the same rising edge that takes the data
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            miscompares++;
        end
        got = rdata;
        got_resp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pins();
        @(negedge clk);
        chk({power, level, ext_sel, irq, wake}, pexp());
        @(posedge clk);
    endtask

    task automatic wctl(input int dir, input int en, input int lvl);
        m_dir = dir;
        m_en = en;
        m_lvl = lvl;
        bus(1'b1, svd_pkg::OFS_CONTROL, ctl(0));
    endtask

    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        pins();
        bus(1'b0, svd_pkg::OFS_CONTROL, 32'h0);
        chk(got, 32'h05);
        chk(got_resp, svd_pkg::RESP_OKAY);
        bus(1'b0, 5'h14, 32'h0);
        chk(got_resp, svd_pkg::RESP_SLVERR);
        chk(got, 32'h0);
        be <= 4'h0;
        bus(1'b1, svd_pkg::OFS_CONTROL, 32'h9F);
        be <= 4'h1;
        bus(1'b0, svd_pkg::OFS_CONTROL, 32'h0);
        chk(got, 32'h05);
        $display("test reset and refusals done");
        for (int i = 0; i < 16; i++)
        begin
            msk = (i == 15) ? 16'h8000 : 16'h0001 << i;
            sup <= (i % 2) ? 16'h0000 : 16'hFFFF;
            wctl(0, 0, i);
            wctl(i % 2, 0, i);
            wctl(i % 2, 1, i);
            m_flag = 0;
            bus(1'b1, svd_pkg::OFS_FLAG, 32'h4);
            pins();
            bus(1'b0, svd_pkg::OFS_CONTROL, 32'h0);
            chk(got, ctl(0));
            // Short excursion while settling must be swallowed
            sup <= sup ^ msk;
            repeat (4) @(posedge clk);
            sup <= sup ^ msk;
            bus(1'b0, svd_pkg::OFS_FLAG, 32'h0);
            chk(got, 32'h0);
            repeat (SETTLE + 10) @(posedge clk);
            bus(1'b0, svd_pkg::OFS_CONTROL, 32'h0);
            chk(got, ctl(1));
            sup <= sup ^ ~msk;
            m_gie = {$random(seed)} % 2;
            m_ie = 1;
            bus(1'b1, svd_pkg::OFS_IRQ_ENABLE, 32'h4);
            bus(1'b1, svd_pkg::OFS_IRQ_CONTROL, m_gie << 7);
            bus(1'b0, svd_pkg::OFS_FLAG, 32'h0);
            chk(got, 32'h0);
            sleep <= 1'($random(seed));
            sup <= sup ^ msk;
            repeat (8) @(posedge clk);
            m_flag = 1;
            bus(1'b0, svd_pkg::OFS_FLAG, 32'h0);
            chk(got, 32'h4);
            bus(1'b0, svd_pkg::OFS_MONITOR, 32'h0);
            chk(got, (i % 2) | 2 | (sleep << 2));
            pins();
            m_gie = 1;
            bus(1'b1, svd_pkg::OFS_IRQ_CONTROL, 32'h80);
            bus(1'b0, svd_pkg::OFS_IRQ_CONTROL, 32'h0);
            chk(got, 32'h80);
            pins();
            m_flag = 0;
            bus(1'b1, svd_pkg::OFS_FLAG, 32'h4);
            repeat (8) @(posedge clk);
            pins();
            wctl(i % 2, 0, i);
            bus(1'b0, svd_pkg::OFS_CONTROL, 32'h0);
            chk(got, ctl(0));
            m_ie = 0;
            bus(1'b1, svd_pkg::OFS_IRQ_ENABLE, 32'h0);
            $display("test level %0d direction %0d done", i, i % 2);
        end
        summarize();
    end
endmodule
